/* File: hw/adapter_tuning_registers.sv */
// Adapter tuning register bank: commit level, PHY options, LED, bursts, max frame
`timescale 1ns/1ps
module adapter_tuning_registers (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic bus_reset_n_i,
    // Indirect register access
    input wire logic req_valid_i,
    input wire tuning_pkg::reg_req_s req_i,
    output logic [31:0] rdata_o,
    // Controller state and options
    input wire logic controller_run_control_i,
    input wire logic serial_mii_option_i,
    input wire logic pass_fcs_option_i,
    input wire logic pass_errored_frames_i,
    // Transmit side and DMA bursts
    input wire logic tx_underrun_abort_i,
    input wire logic [11:0] tx_fifo_bytes_i,
    input wire logic tx_whole_frame_i,
    input wire logic tx_frame_pending_i,
    input wire logic tx_fifo_wait_room_i,
    output logic tx_start_o,
    output logic [9:0] tx_burst_bytes_o,
    output logic [9:0] rx_burst_bytes_o,
    output tuning_pkg::phy_opt_s phy_opt_o,
    // Boot ROM shared pins
    input wire logic ext_high_latch_strobe_i,
    input wire logic ext_low_latch_strobe_i,
    input wire logic ext_rom_output_enable_n_i,
    output logic [7:0] external_addr_data_pins_o,
    output logic external_addr_data_pins_oe_o,
    // Receive frame check
    input wire logic rx_frame_end_i,
    input wire logic [16:0] rx_frame_len_i,
    output logic rx_accept_o,
    output logic rx_drop_o,
    output logic rx_overrun_o,
    output logic [16:0] rx_report_len_o,
    output logic [16:0] rx_valid_len_o,
    // Interrupt events
    input wire tuning_pkg::irq_evt_s irq_evt_i,
    output tuning_pkg::irq_evt_s irq_evt_o
);
    logic [3:0] commit_level_r;
    logic [3:0] phy_opt_r;
    logic [7:0] led_output_byte_r;
    logic [7:0] dma_burst_sizes_r;
    logic [15:0] max_rx_frame_size_r;
    logic [7:0] interrupt_disable_byte_r;
    logic rst_n;
    logic in_reset;
    logic wr_commit;
    logic wr_44;
    logic wr_48;
    logic [12:0] commit_bytes;
    logic threshold_met;
    logic deadlock;
    logic [1:0] hl_sync_r;
    logic [1:0] ll_sync_r;
    logic [1:0] oe_sync_r;
    logic rom_idle;

    // Adapter reset and bus reset both clear the bank
    assign rst_n = reset_n_i & bus_reset_n_i;
    assign in_reset = !controller_run_control_i;
    assign wr_commit = req_valid_i && req_i.wr && req_i.addr == tuning_pkg::OFS_COMMIT;
    assign wr_44 = req_valid_i && req_i.wr && req_i.addr == tuning_pkg::OFS_LED_BURST_MAX;
    assign wr_48 = req_valid_i && req_i.wr && req_i.addr == tuning_pkg::OFS_INT_DISABLE;

    // ****************
    // Burst size decode
    // ****************
    function automatic logic [9:0] burst_bytes(input logic [3:0] code);
        logic [3:0] c;
        c = (code > tuning_pkg::BURST_CODE_CAP) ? tuning_pkg::BURST_CODE_CAP : code;
        // Codes 6..F fall back to the largest burst
        burst_bytes = 10'(10'h001 << (c + tuning_pkg::BURST_SHIFT_BASE));
    endfunction : burst_bytes

    // ****************
    // Commit register
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            commit_level_r <= tuning_pkg::COMMIT_RESET; // see R1
        end else if (tx_underrun_abort_i) begin
            // Hardware bump wins over a concurrent software write
            if (commit_level_r != tuning_pkg::COMMIT_MAX) begin // see R23
                commit_level_r <= commit_level_r + 4'h1; // see R2
            end
        end else if (wr_commit && req_i.be[3] && in_reset) begin // see R7
            commit_level_r <= req_i.wdata[tuning_pkg::COMMIT_HI:tuning_pkg::COMMIT_LO];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            phy_opt_r <= tuning_pkg::PHYOPT_RESET;
        end else if (wr_commit && req_i.be[3]) begin
            phy_opt_r <= req_i.wdata[tuning_pkg::PHYOPT_HI:tuning_pkg::PHYOPT_LO];
        end
    end

    // ****************
    // LED, burst, max frame
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            led_output_byte_r <= tuning_pkg::LED_RESET;
        end else if (wr_44 && req_i.be[0]) begin
            led_output_byte_r <= req_i.wdata[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dma_burst_sizes_r <= tuning_pkg::BURST_RESET; // see R10
        end else if (wr_44 && req_i.be[1] && in_reset) begin // see R10
            dma_burst_sizes_r <= req_i.wdata[15:8];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            max_rx_frame_size_r <= tuning_pkg::MAX_RX_FRAME_SIZE_RESET;
        end else if (wr_44) begin
            if (req_i.be[2]) begin
                max_rx_frame_size_r[7:0] <= req_i.wdata[23:16];
            end
            if (req_i.be[3]) begin
                max_rx_frame_size_r[15:8] <= req_i.wdata[31:24];
            end
        end
    end

    // Limitation: writes outside reset are taken; software must keep to reset time
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_disable_byte_r <= tuning_pkg::INTERRUPT_DISABLE_BYTE_RESET;
        end else if (wr_48 && req_i.be[0]) begin // see R21
            interrupt_disable_byte_r <= req_i.wdata[7:0] & tuning_pkg::INTERRUPT_DISABLE_BYTE_USED; // see R20
        end
    end

    // ****************
    // Read path
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 32'h00000000;
        end else if (req_valid_i && !req_i.wr) begin
            unique case (req_i.addr)
                tuning_pkg::OFS_COMMIT:
                    rdata_o <= {commit_level_r, phy_opt_r, 24'h000000};
                tuning_pkg::OFS_LED_BURST_MAX:
                    rdata_o <= {max_rx_frame_size_r, dma_burst_sizes_r, led_output_byte_r};
                tuning_pkg::OFS_INT_DISABLE:
                    rdata_o <= {24'h000000, interrupt_disable_byte_r};
                default:
                    rdata_o <= 32'h00000000;
            endcase
        end
    end

    // ****************
    // Transmit commit and bursts
    // ****************
    assign commit_bytes = 13'(13'h0001 << (commit_level_r + tuning_pkg::COMMIT_SHIFT_BASE));
    always_comb begin
        if (commit_level_r >= tuning_pkg::COMMIT_WHOLE_MIN) begin
            threshold_met = tx_whole_frame_i; // see R3
        end else begin
            threshold_met = {1'b0, tx_fifo_bytes_i} >= commit_bytes; // see R3
        end
        // Both sides waiting on the FIFO would stall forever
        deadlock = commit_level_r >= tuning_pkg::COMMIT_DEADLOCK_MIN
                   && tx_fifo_wait_room_i; // see R4
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_start_o <= 1'b0;
        end else begin
            tx_start_o <= tx_frame_pending_i && (threshold_met || deadlock); // see R4
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_burst_bytes_o <= 10'h000;
            rx_burst_bytes_o <= 10'h000;
        end else begin
            tx_burst_bytes_o <= burst_bytes(dma_burst_sizes_r[7:4]); // see R11
            rx_burst_bytes_o <= burst_bytes(dma_burst_sizes_r[3:0]); // see R12
        end
    end

    // ****************
    // PHY option pins
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            phy_opt_o <= '0;
        end else if (serial_mii_option_i) begin // see R5
            phy_opt_o.tx_nibble_bit3 <= phy_opt_r[3]; // see R6
            phy_opt_o.tx_nibble_bit2 <= phy_opt_r[2]; // see R6
            phy_opt_o.tx_nibble_bit1 <= phy_opt_r[1]; // see R6
            phy_opt_o.tx_error_pin <= 1'b0; // see R6
        end else begin
            phy_opt_o <= '0;
        end
    end

    // ****************
    // LED on shared pins
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            hl_sync_r <= 2'h0;
            ll_sync_r <= 2'h0;
            oe_sync_r <= 2'h3;
        end else begin
            hl_sync_r <= {hl_sync_r[0], ext_high_latch_strobe_i};
            ll_sync_r <= {ll_sync_r[0], ext_low_latch_strobe_i};
            oe_sync_r <= {oe_sync_r[0], ext_rom_output_enable_n_i};
        end
    end
    assign rom_idle = !hl_sync_r[1] && !ll_sync_r[1] && oe_sync_r[1];

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            external_addr_data_pins_o <= 8'hff;
            external_addr_data_pins_oe_o <= 1'b0;
        end else begin
            external_addr_data_pins_o <= ~led_output_byte_r; // see R9
            external_addr_data_pins_oe_o <= rom_idle; // see R8
        end
    end

    // ****************
    // Interrupt gating
    // ****************
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_evt_o <= '0;
        end else begin
            irq_evt_o.tx_eoc <= irq_evt_i.tx_eoc
                && !interrupt_disable_byte_r[tuning_pkg::IDIS_TX_EOC]; // see R18
            irq_evt_o.rx_eof <= irq_evt_i.rx_eof
                && !interrupt_disable_byte_r[tuning_pkg::IDIS_RX_EOF]; // see R19
            irq_evt_o.rx_eoc <= irq_evt_i.rx_eoc
                && !interrupt_disable_byte_r[tuning_pkg::IDIS_RX_EOC]; // see R20
        end
    end

    // ****************
    // Receive size check
    // ****************
    rx_size_check u_rx_size_check (
        .mclk_i(mclk_i),
        .reset_n_i(rst_n),
        .max_rx_frame_size_i(max_rx_frame_size_r),
        .pass_fcs_option_i(pass_fcs_option_i),
        .pass_errored_frames_i(pass_errored_frames_i),
        .frame_end_i(rx_frame_end_i),
        .frame_len_i(rx_frame_len_i),
        .accept_o(rx_accept_o),
        .drop_o(rx_drop_o),
        .overrun_o(rx_overrun_o),
        .report_len_o(rx_report_len_o),
        .valid_len_o(rx_valid_len_o)
    );
endmodule : adapter_tuning_registers

/* File: hw/rx_size_check.sv */
// Receive frame size check against the programmed maximum
`timescale 1ns/1ps
module rx_size_check (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Configuration
    input wire logic [15:0] max_rx_frame_size_i,
    input wire logic pass_fcs_option_i,
    input wire logic pass_errored_frames_i,
    // Frame end report
    input wire logic frame_end_i,
    input wire logic [16:0] frame_len_i,
    // Verdict
    output logic accept_o,
    output logic drop_o,
    output logic overrun_o,
    output logic [16:0] report_len_o,
    output logic [16:0] valid_len_o
);
    logic [16:0] limit;
    logic [16:0] eff_len;
    logic oversize;

    // ****************
    // Limit and compare
    // ****************
    always_comb begin
        limit = (max_rx_frame_size_i == 16'h0000) ? tuning_pkg::MAX_RX_FRAME_SIZE_ZERO_LIMIT
                                                  : {1'b0, max_rx_frame_size_i}; // see R14
        // Check bytes sent to host are data for sizing
        eff_len = pass_fcs_option_i ? frame_len_i + tuning_pkg::FCS_BYTES
                                    : frame_len_i; // see R15
        oversize = eff_len > limit;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            accept_o <= 1'b0;
            drop_o <= 1'b0;
            overrun_o <= 1'b0;
            report_len_o <= 17'h00000;
            valid_len_o <= 17'h00000;
        end else begin
            accept_o <= frame_end_i && (!oversize || pass_errored_frames_i); // see R16
            drop_o <= frame_end_i && oversize && !pass_errored_frames_i; // see R13
            overrun_o <= frame_end_i && oversize; // see R17
            if (frame_end_i) begin
                report_len_o <= oversize ? limit : eff_len; // see R16
                // Tail of a truncated frame is not trustworthy
                valid_len_o <= oversize ? limit - tuning_pkg::CORRUPT_TAIL_BYTES : eff_len;
            end
        end
    end
endmodule : rx_size_check

/* File: shared/tuning_pkg.sv */
// Constants and carrier types for the adapter tuning register bank
// Notes on behaviour
// R1: Commit level clears to zero on reset
// R2: Underrun abort raises commit level by one
// R3: Start transmit when FIFO holds commit bytes
// R4: Level three or more breaks FIFO deadlock
// R5: Serial MII option drives PHY options out
// R6: Bits 27..25 to data pins, error zero
// R7: Commit nibble writable only while held reset
// R8: LED byte on pins when ROM idle
// R9: LED pins show inverse of written byte
// R10: Burst sizes writable in reset, reset 0x22
// R11: Transmit burst limited by upper nibble code
// R12: Receive burst limited by lower nibble code
// R13: Oversize frame dropped and counted overrun
// R14: Zero maximum means 64K byte limit
// R15: Passed check bytes count toward frame size
// R16: Errored mode writes oversize, length equals limit
// R17: Every oversize frame bumps overrun counter
// R18: Bit 2 masks transmit end-of-channel interrupts
// R19: Bit 1 masks receive end-of-frame interrupts
// R20: Bit 0 masks receive end-of-channel; rest reserved
// R21: Software writes disable byte only in reset; the bank takes writes to it at any time
// R22: Transmit end-of-frame masked via threshold zero
// R23: Commit level saturates at highest code
package tuning_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] OFS_COMMIT = 8'h40;
    localparam logic [7:0] OFS_LED_BURST_MAX = 8'h44;
    localparam logic [7:0] OFS_INT_DISABLE = 8'h48;
    localparam logic [3:0] COMMIT_RESET = 4'h0;
    localparam logic [3:0] COMMIT_MAX = 4'hf;
    localparam logic [3:0] COMMIT_DEADLOCK_MIN = 4'h3;
    localparam logic [3:0] COMMIT_WHOLE_MIN = 4'h5;
    localparam logic [3:0] PHYOPT_RESET = 4'h0;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [7:0] BURST_RESET = 8'h22;
    localparam logic [15:0] MAX_RX_FRAME_SIZE_RESET = 16'h0000;
    localparam logic [7:0] INTERRUPT_DISABLE_BYTE_RESET = 8'h00;
    localparam logic [7:0] INTERRUPT_DISABLE_BYTE_USED = 8'h07;
    localparam int COMMIT_HI = 31;
    localparam int COMMIT_LO = 28;
    localparam int PHYOPT_HI = 27;
    localparam int PHYOPT_LO = 24;
    localparam int TXB_HI = 15;
    localparam int TXB_LO = 12;
    localparam int RXB_HI = 11;
    localparam int RXB_LO = 8;
    localparam int IDIS_TX_EOC = 2;
    localparam int IDIS_RX_EOF = 1;
    localparam int IDIS_RX_EOC = 0;
    localparam logic [16:0] MAX_RX_FRAME_SIZE_ZERO_LIMIT = 17'h10000;
    localparam logic [16:0] FCS_BYTES = 17'h00004;
    localparam logic [16:0] CORRUPT_TAIL_BYTES = 17'h00008;
    localparam logic [3:0] BURST_CODE_CAP = 4'h5;
    localparam logic [3:0] COMMIT_SHIFT_BASE = 4'h6;
    localparam logic [3:0] BURST_SHIFT_BASE = 4'h4;

    // ****************
    // Carriers
    // ****************
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic tx_nibble_bit3;
        logic tx_nibble_bit2;
        logic tx_nibble_bit1;
        logic tx_error_pin;
    } phy_opt_s;

    typedef struct packed {
        logic tx_eoc;
        logic rx_eof;
        logic rx_eoc;
    } irq_evt_s;
endpackage : tuning_pkg

/* File: testbench/adapter_tuning_monitor.sv */
// Port checker of the tuning register bank
`timescale 1ns/1ps
module adapter_tuning_monitor (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic bus_reset_n_i,
    // Observed ports
    input wire logic req_valid_i,
    input wire tuning_pkg::reg_req_s req_i,
    input wire logic controller_run_control_i,
    input wire logic serial_mii_option_i,
    input wire logic pass_fcs_option_i,
    input wire logic pass_errored_frames_i,
    input wire logic tx_underrun_abort_i,
    input wire logic [11:0] tx_fifo_bytes_i,
    input wire logic tx_whole_frame_i,
    input wire logic tx_frame_pending_i,
    input wire logic tx_fifo_wait_room_i,
    input wire logic tx_start_o,
    input wire logic [9:0] tx_burst_bytes_o,
    input wire logic [9:0] rx_burst_bytes_o,
    input wire tuning_pkg::phy_opt_s phy_opt_o,
    input wire logic ext_high_latch_strobe_i,
    input wire logic ext_low_latch_strobe_i,
    input wire logic ext_rom_output_enable_n_i,
    input wire logic [7:0] external_addr_data_pins_o,
    input wire logic external_addr_data_pins_oe_o,
    input wire logic rx_frame_end_i,
    input wire logic [16:0] rx_frame_len_i,
    input wire logic rx_drop_o,
    input wire logic rx_overrun_o,
    input wire logic [16:0] rx_report_len_o,
    input wire tuning_pkg::irq_evt_s irq_evt_i,
    input wire tuning_pkg::irq_evt_s irq_evt_o
);
    // ****************
    // Shadow registers
    // ****************
    logic rst_n;
    logic [7:0] wa;
    logic [3:0] cm_r, ph_r;
    logic [7:0] led_r, bs_r, dis_r;
    logic [15:0] mx_r;
    logic [16:0] lim, len;
    logic thr, over;
    assign rst_n = reset_n_i & bus_reset_n_i;
    assign wa = (req_valid_i && req_i.wr) ? req_i.addr : 8'hff;
    assign lim = (mx_r == 16'h0000) ? tuning_pkg::MAX_RX_FRAME_SIZE_ZERO_LIMIT : {1'b0, mx_r};
    assign len = rx_frame_len_i + (pass_fcs_option_i ? tuning_pkg::FCS_BYTES : 17'h00000);
    assign over = len > lim;
    assign thr = (cm_r < 4'h5) ? ({5'h00, tx_fifo_bytes_i} >= (17'h00040 << cm_r)) : tx_whole_frame_i;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            {cm_r, ph_r, led_r, dis_r, mx_r} <= '0;
            bs_r <= 8'h22;
        end else begin
            if (tx_underrun_abort_i) cm_r <= (cm_r == 4'hf) ? cm_r : cm_r + 4'h1;
            else if (wa == 8'h40 && req_i.be[3] && !controller_run_control_i) cm_r <= req_i.wdata[31:28];
            if (wa == 8'h40 && req_i.be[3]) ph_r <= req_i.wdata[27:24];
            if (wa == 8'h44 && req_i.be[0]) led_r <= req_i.wdata[7:0];
            if (wa == 8'h44 && req_i.be[1] && !controller_run_control_i) bs_r <= req_i.wdata[15:8];
            if (wa == 8'h44 && req_i.be[2]) mx_r[7:0] <= req_i.wdata[23:16];
            if (wa == 8'h44 && req_i.be[3]) mx_r[15:8] <= req_i.wdata[31:24];
            if (wa == 8'h48 && req_i.be[0]) dis_r <= req_i.wdata[7:0];
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    a_commit_start: assert property (
        tx_start_o == $past(tx_frame_pending_i && (thr || (cm_r >= 4'h3 && tx_fifo_wait_room_i))))
        else $error("transmit start differs from commit level");
    a_phy_pins: assert property (
        phy_opt_o == $past(serial_mii_option_i ? {ph_r[3:1], 1'b0} : 4'h0))
        else $error("phy option pins wrong");
    a_led_invert: assert property (
        external_addr_data_pins_o == ~$past(led_r)) else $error("led pins not inverted byte");
    a_led_release: assert property (
        !ext_rom_output_enable_n_i [*4] |=> !external_addr_data_pins_oe_o)
        else $error("led driven during rom access");
    a_led_drive: assert property (
        (ext_rom_output_enable_n_i && !ext_high_latch_strobe_i && !ext_low_latch_strobe_i) [*5]
        |=> external_addr_data_pins_oe_o) else $error("led not driven while rom idle");
    a_tx_burst: assert property ($past(rst_n) |->
        tx_burst_bytes_o == (10'h010 << $past((bs_r[7:4] > 4'h5) ? 4'h5 : bs_r[7:4])))
        else $error("tx burst size wrong");
    a_rx_burst: assert property ($past(rst_n) |->
        rx_burst_bytes_o == (10'h010 << $past((bs_r[3:0] > 4'h5) ? 4'h5 : bs_r[3:0])))
        else $error("rx burst size wrong");
    a_rx_overrun: assert property (
        rx_frame_end_i |=> (rx_overrun_o == $past(over))
        && (rx_drop_o == $past(over && !pass_errored_frames_i))) else $error("frame verdict wrong");
    a_rx_report: assert property (
        rx_frame_end_i && over |=> rx_report_len_o == $past(lim)) else $error("report length wrong");
    a_irq_gate: assert property (
        irq_evt_o == $past(irq_evt_i & ~dis_r[2:0])) else $error("interrupt gating wrong");

    c_oversize: cover property (rx_frame_end_i && over);
    c_deadlock: cover property (tx_frame_pending_i && tx_fifo_wait_room_i && cm_r == 4'h3);
    c_masked: cover property (irq_evt_i.tx_eoc && dis_r[2]);
endmodule : adapter_tuning_monitor

bind adapter_tuning_registers adapter_tuning_monitor mon (.*);

/* File: testbench/adapter_tuning_registers_tb_top.sv */
// Self-checking testbench of the tuning register bank
`timescale 1ns/1ps
module adapter_tuning_registers_tb_top;
    logic mclk_i = 1'b0;
    logic reset_n_i, bus_reset_n_i, req_valid_i, controller_run_control_i;
    tuning_pkg::reg_req_s req_i;
    logic [31:0] rdata_o;
    logic serial_mii_option_i, pass_fcs_option_i, pass_errored_frames_i, tx_underrun_abort_i;
    logic [11:0] tx_fifo_bytes_i;
    logic tx_whole_frame_i, tx_frame_pending_i, tx_fifo_wait_room_i, tx_start_o;
    logic [9:0] tx_burst_bytes_o, rx_burst_bytes_o;
    tuning_pkg::phy_opt_s phy_opt_o;
    logic ext_high_latch_strobe_i, ext_low_latch_strobe_i, ext_rom_output_enable_n_i;
    logic [7:0] external_addr_data_pins_o;
    logic external_addr_data_pins_oe_o, rx_frame_end_i, rx_accept_o, rx_drop_o, rx_overrun_o;
    logic [16:0] rx_frame_len_i, rx_report_len_o, rx_valid_len_o;
    tuning_pkg::irq_evt_s irq_evt_i, irq_evt_o;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] d;

    always #2.5 mclk_i = ~mclk_i;
    adapter_tuning_registers uut (.*);
    host_driver_model drv (.mclk_i, .req_valid_o(req_valid_i), .req_o(req_i), .rdata_i(rdata_o),
                           .controller_run_control_o(controller_run_control_i));

    // ****************
    // Tasks
    // ****************
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        drv.access(1'b0, a, 4'hf, 32'h0, d);
        cmp(d, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        drv.access(1'b1, a, be, v, d);
        @(negedge mclk_i);
    endtask : wr
    task automatic rx_case(input logic [16:0] len, input logic fcs, input logic pass_errored_frames,
                           input logic [2:0] exp, input logic [16:0] rep);
        rx_frame_len_i = len;
        pass_fcs_option_i = fcs;
        pass_errored_frames_i = pass_errored_frames;
        rx_frame_end_i = 1'b1;
        @(negedge mclk_i);
        rx_frame_end_i = 1'b0;
        cmp({rx_accept_o, rx_drop_o, rx_overrun_o}, exp);
        if (exp[0]) cmp({rx_report_len_o, rx_valid_len_o}, {rep, rep - 17'd8});
    endtask : rx_case
    task tally_and_finish();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************
    // Sequence
    // ****************
    initial begin
        {reset_n_i, serial_mii_option_i, pass_fcs_option_i, pass_errored_frames_i} = '0;
        {tx_underrun_abort_i, tx_whole_frame_i, tx_frame_pending_i, tx_fifo_wait_room_i} = '0;
        {ext_high_latch_strobe_i, ext_low_latch_strobe_i, rx_frame_end_i} = '0;
        {bus_reset_n_i, ext_rom_output_enable_n_i} = 2'b11;
        {tx_fifo_bytes_i, rx_frame_len_i, irq_evt_i} = '0;
        repeat (4) @(negedge mclk_i);
        reset_n_i = 1'b1;
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h44, 32'h0000_2200);
        cmp(external_addr_data_pins_o, 8'hff);
        // Protected fields refuse writes while running
        drv.controller_run_control_o = 1'b1;
        wr(8'h40, 4'hf, 32'hffff_ffff);
        wr(8'h44, 4'hf, 32'h1234_775a);
        rd_chk(8'h40, 32'h0f00_0000);
        rd_chk(8'h44, 32'h1234_225a);
        cmp(external_addr_data_pins_o, 8'ha5);
        serial_mii_option_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        cmp(phy_opt_o, 4'he);
        serial_mii_option_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        cmp(phy_opt_o, 4'h0);
        drv.controller_run_control_o = 1'b0;
        for (int c = 0; c < 16; c++) begin
            wr(8'h44, 4'h2, {16'h0, c[3:0], 4'hf - c[3:0], 8'h0});
            cmp(tx_burst_bytes_o, 10'h010 << ((c > 5) ? 5 : c));
            cmp(rx_burst_bytes_o, 10'h010 << ((15 - c > 5) ? 5 : 15 - c));
        end
        // Threshold just below and at each commit size, levels 0..4; whole frame at level 5
        tx_frame_pending_i = 1'b1;
        for (int c = 0; c < 6; c++) begin
            wr(8'h40, 4'h8, {c[3:0], 28'h0});
            tx_fifo_bytes_i = (c < 5) ? 12'((64 << c) - 1) : 12'hfff;
            repeat (2) @(negedge mclk_i);
            cmp(tx_start_o, 1'b0);
            tx_fifo_bytes_i = (c < 5) ? 12'(64 << c) : 12'hfff;
            tx_whole_frame_i = (c == 5);
            repeat (2) @(negedge mclk_i);
            cmp(tx_start_o, 1'b1);
            tx_whole_frame_i = 1'b0;
        end
        tx_fifo_bytes_i = 12'h000;
        tx_fifo_wait_room_i = 1'b1;
        for (int c = 2; c < 4; c++) begin
            wr(8'h40, 4'h8, {c[3:0], 28'h0});
            repeat (2) @(negedge mclk_i);
            cmp(tx_start_o, c == 3);
        end
        {tx_fifo_wait_room_i, tx_frame_pending_i} = 2'b00;
        wr(8'h40, 4'h8, 32'h0);
        for (int i = 1; i < 18; i++) begin
            tx_underrun_abort_i = 1'b1;
            @(negedge mclk_i);
            tx_underrun_abort_i = 1'b0;
            rd_chk(8'h40, {(i > 15) ? 4'hf : i[3:0], 28'h0});
        end
        // Frames against a 128 byte limit, then the zero default
        wr(8'h44, 4'hc, 32'h0080_0000);
        rx_case(17'd128, 1'b0, 1'b0, 3'b100, 17'd0);
        rx_case(17'd133, 1'b0, 1'b0, 3'b011, 17'd128);
        rx_case(17'd133, 1'b0, 1'b1, 3'b101, 17'd128);
        rx_case(17'd125, 1'b1, 1'b0, 3'b011, 17'd128);
        rx_case(17'd124, 1'b1, 1'b0, 3'b100, 17'd0);
        wr(8'h44, 4'hc, 32'h0);
        rx_case(17'h10000, 1'b0, 1'b0, 3'b100, 17'd0);
        rx_case(17'h10001, 1'b0, 1'b1, 3'b101, 17'h10000);
        for (int m = 0; m < 8; m++) begin
            wr(8'h48, 4'h1, {24'h0, 5'h1f, m[2:0]});
            rd_chk(8'h48, {29'h0, m[2:0]});
            irq_evt_i = 3'b111;
            @(negedge mclk_i);
            irq_evt_i = 3'b000;
            cmp(irq_evt_o, 3'(~m[2:0]));
        end
        for (int s = 0; s < 3; s++) begin
            {ext_high_latch_strobe_i, ext_low_latch_strobe_i, ext_rom_output_enable_n_i} =
                3'b001 ^ (3'b100 >> s);
            repeat (5) @(negedge mclk_i);
            cmp(external_addr_data_pins_oe_o, 1'b0);
            {ext_high_latch_strobe_i, ext_low_latch_strobe_i, ext_rom_output_enable_n_i} = 3'b001;
            repeat (5) @(negedge mclk_i);
            cmp(external_addr_data_pins_oe_o, 1'b1);
        end
        bus_reset_n_i = 1'b0;
        @(negedge mclk_i);
        bus_reset_n_i = 1'b1;
        rd_chk(8'h44, 32'h0000_2200);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h4c, 32'h0);
        tally_and_finish();
    end

    // Run needs under ten microseconds
    initial begin
        #50us;
        num_errors++;
        tally_and_finish();
    end
endmodule : adapter_tuning_registers_tb_top

/* File: testbench/host_driver_model.sv */
// Host driver model: indirect register accesses into the tuning bank
`timescale 1ns/1ps
module host_driver_model (
    // Clock
    input wire logic mclk_i,
    // Register access
    output logic req_valid_o,
    output tuning_pkg::reg_req_s req_o,
    input wire logic [31:0] rdata_i,
    // Controller state
    output logic controller_run_control_o
);
    // ****************
    // Access
    // ****************
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
        controller_run_control_o = 1'b0;
    end

    // Tx end-of-frame masking belongs to the threshold, never to this bank
    // Called at a falling edge; returns two falling edges later with the read data
    task access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                input logic [31:0] wdata, output logic [31:0] rdata);
        if (wr && addr == tuning_pkg::OFS_INT_DISABLE) controller_run_control_o = 1'b0;
        req_o = '{wr: wr, addr: addr, be: be, wdata: wdata};
        req_valid_o = 1'b1;
        @(negedge mclk_i);
        req_valid_o = 1'b0;
        // A released bus must not keep showing the old request
        req_o = ~req_o;
        @(negedge mclk_i);
        rdata = rdata_i;
    endtask : access
endmodule : host_driver_model
